// ### rtl/jcsb_port.sv
// test port instructions: config load, spi access, serializer, boundary
`timescale 1ns/1ps
`include "jcsb_params.svh"
module jcsb_port import jcsb_pkg::*; (
  // system
  input wire logic clk,
  input wire logic arst_n,
  // test access port
  input wire logic tck,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic tap_reset,
  input wire logic capture_ir,
  input wire logic shift_ir,
  input wire logic update_ir,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  // straps
  input wire logic [3:0] config_mode_straps,
  // spi pins
  output logic spi_clk_o,
  output logic spi_clk_oe,
  output logic spi_cs_n_o,
  output logic spi_cs_n_oe,
  output logic spi_serial_out,
  output logic spi_serial_out_oe,
  input wire logic spi_serial_in,
  // configuration bytes
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid,
  // serializer register file
  output logic sd_req,
  output logic sd_we,
  output logic [7:0] sd_addr,
  output logic [15:0] sd_wdata,
  output logic [15:0] sd_mask,
  input wire logic [15:0] sd_rdata,
  // fabric access to serializer file
  input wire logic fab_req,
  input wire logic fab_we,
  input wire logic [7:0] fab_addr,
  input wire logic [15:0] fab_wdata,
  input wire logic [15:0] fab_mask,
  output logic fab_grant,
  // boundary scan
  input wire logic [`JCSB_BS_W-1:0] bs_capture,
  output logic [`JCSB_BS_W-1:0] bs_pin_drive,
  output logic bs_extest,
  output logic [1:0] test_mode_select
);
  logic rst_c1, rst_n, rst_t1, rst_tck_n;
  jcsb_instr_type ir_sh, ir, prev_ir;
  logic [`JCSB_BS_W-1:0] dr, bs_upd;
  logic [2:0] cfg_cnt;
  logic [7:0] cfg_hold;
  logic cfg_tog, fa_tog, sd_tog, byp_cap, busy_tck;
  logic [5:0] pg_ptr;
  logic [31:0] page_mem [0:`JCSB_PAGE_WORDS-1];
  logic [`JCSB_FA_W-1:0] fa_word;
  logic [`JCSB_SD_W-1:0] sd_word;
  logic [1:0] testmode;
  logic [2:0] bz_s, tg_s1, tg_s2, tg_s3, tg_seen;
  logic [3:0] st_s1, st_s2, st_s3, straps_q;
  logic sd_jt, sd_jt_d;
  logic [15:0] sd_read;
  logic [5:0] eng_idx;
  logic eng_busy, eng_sclk, eng_cs_n, eng_mosi;
  logic [31:0] eng_rx;

  function automatic logic [8:0] dr_len(input jcsb_instr_type i);
    case (i)
      `JCSB_I_CONFIG: dr_len = 9'(`JCSB_CFG_W);
      `JCSB_I_PAGE: dr_len = 9'(`JCSB_PG_W);
      `JCSB_I_FLASH: dr_len = 9'(`JCSB_FA_W);
      `JCSB_I_RXDATA: dr_len = 9'(`JCSB_RX_W);
      `JCSB_I_TMODE: dr_len = 9'(`JCSB_TM_W);
      `JCSB_I_SDACC: dr_len = 9'(`JCSB_SD_W);
      `JCSB_I_SDRD: dr_len = 9'(`JCSB_SDR_W);
      `JCSB_I_SAMPLE: dr_len = 9'(`JCSB_BS_W);
      `JCSB_I_EXTEST: dr_len = 9'(`JCSB_BS_W);
      default: dr_len = 9'h001;
    endcase
  endfunction

  function automatic logic [`JCSB_BS_W-1:0] shift_in(
      input logic [`JCSB_BS_W-1:0] v, input logic b, input logic [8:0] n);
    shift_in = v >> 1;
    shift_in[n - 9'h001] = b;
  endfunction

  function automatic logic [31:0] bswap(input logic [31:0] w);
    bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // reset release, one copy per domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_c1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_c1 <= 1'b1;
      rst_n <= rst_c1;
    end
  end

  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      rst_t1 <= 1'b0;
      rst_tck_n <= 1'b0;
    end else begin
      rst_t1 <= 1'b1;
      rst_tck_n <= rst_t1;
    end
  end

  // instruction register
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      ir_sh <= `JCSB_IR_CAPT;
      ir <= `JCSB_I_BYPASS;
      prev_ir <= `JCSB_I_BYPASS;
    end else if (tap_reset) begin
      ir_sh <= `JCSB_IR_CAPT;
      ir <= `JCSB_I_BYPASS;
      prev_ir <= `JCSB_I_BYPASS;
    end else begin
      if (capture_ir) ir_sh <= `JCSB_IR_CAPT;
      else if (shift_ir) ir_sh <= {tdi, ir_sh[5:1]};
      if (update_ir) begin
        prev_ir <= ir;
        ir <= ir_sh;
      end
    end
  end

  wire is_cfg = (ir == `JCSB_I_CONFIG);
  wire is_page = (ir == `JCSB_I_PAGE);
  wire is_fa = (ir == `JCSB_I_FLASH);
  wire is_rx = (ir == `JCSB_I_RXDATA);
  wire is_busy = (ir == `JCSB_I_BUSY);
  wire is_byp = (ir == `JCSB_I_SPIBYP);
  wire is_tm = (ir == `JCSB_I_TMODE);
  wire is_sda = (ir == `JCSB_I_SDACC);
  wire is_sdr = (ir == `JCSB_I_SDRD);
  wire is_bsc = (ir == `JCSB_I_SAMPLE) || (ir == `JCSB_I_EXTEST);
  wire is_sample_only = (ir == `JCSB_I_SAMPLE);
  wire rx_valid = (prev_ir == `JCSB_I_FLASH);
  wire [`JCSB_BS_W-1:0] cap_rx = {{(`JCSB_BS_W-`JCSB_RX_W){1'b0}},
                                  eng_rx, rx_valid};
  wire [`JCSB_BS_W-1:0] cap_bz = {{(`JCSB_BS_W-1){1'b0}}, busy_tck};
  wire [`JCSB_BS_W-1:0] cap_sd = {{(`JCSB_BS_W-`JCSB_SDR_W){1'b0}}, sd_read};
  wire [`JCSB_BS_W-1:0] cap_val = is_bsc ? bs_capture :
                                  is_rx ? cap_rx :
                                  is_busy ? cap_bz :
                                  is_sdr ? cap_sd : '0;
  wire tdo_sel = shift_ir ? ir_sh[0] : (is_byp ? byp_cap : dr[0]);

  // data register path
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) dr <= '0;
    else if (capture_dr) dr <= cap_val;
    else if (shift_dr) dr <= shift_in(dr, tdi, dr_len(ir));
  end

  // configuration byte packing
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      cfg_cnt <= 3'h0;
      cfg_hold <= 8'h00;
      cfg_tog <= 1'b0;
    end else if (capture_dr) begin
      cfg_cnt <= 3'h0;
    end else if (shift_dr && is_cfg) begin
      cfg_cnt <= cfg_cnt + 3'h1;
      if (cfg_cnt == 3'h7) begin
        cfg_hold <= {tdi, dr[7:1]};
        cfg_tog <= ~cfg_tog;
      end
    end
  end

  // update stage registers
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      pg_ptr <= 6'h00;
      fa_word <= '0;
      fa_tog <= 1'b0;
      sd_word <= '0;
      sd_tog <= 1'b0;
      testmode <= `JCSB_TM_OFF;
      bs_upd <= '0;
    end else if (tap_reset) begin
      pg_ptr <= 6'h00;
      testmode <= `JCSB_TM_OFF;
    end else if (update_ir && ir_sh == `JCSB_I_PAGE) begin
      pg_ptr <= 6'h00;
    end else if (update_dr) begin
      if (is_page) pg_ptr <= pg_ptr + 6'h01;
      if (is_fa) begin
        fa_word <= {dr[`JCSB_FA_W-1:32], bswap(dr[31:0])};
        fa_tog <= ~fa_tog;
      end
      if (is_sda) begin
        sd_word <= dr[`JCSB_SD_W-1:0];
        sd_tog <= ~sd_tog;
      end
      if (is_tm) testmode <= dr[1:0];
      if (is_bsc) bs_upd <= dr;
    end
  end

  always_ff @(posedge tck) begin
    if (update_dr && is_page) page_mem[pg_ptr] <= bswap(dr[31:0]);
  end

  // spi input follows the shift
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) byp_cap <= 1'b0;
    else if (is_byp && shift_dr) byp_cap <= spi_serial_in;
  end

  // output stage on the falling edge
  always_ff @(negedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= tdo_sel;
      tdo_oe <= shift_ir | shift_dr;
    end
  end

  // engine busy into the test clock domain
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bz_s <= 3'h0;
      busy_tck <= 1'b0;
    end else begin
      bz_s <= {bz_s[1:0], eng_busy};
      if (bz_s[1] == bz_s[2]) busy_tck <= bz_s[2];
    end
  end

  // toggle events and straps into the internal clock domain
  wire [2:0] tg_ev = ~(tg_s2 ^ tg_s3) & (tg_s3 ^ tg_seen);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tg_s1 <= 3'h0;
      tg_s2 <= 3'h0;
      tg_s3 <= 3'h0;
      tg_seen <= 3'h0;
      st_s1 <= 4'h0;
      st_s2 <= 4'h0;
      st_s3 <= 4'h0;
      straps_q <= 4'h0;
    end else begin
      tg_s1 <= {sd_tog, fa_tog, cfg_tog};
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      tg_seen <= tg_seen ^ tg_ev;
      st_s1 <= config_mode_straps;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      if (st_s2 == st_s3) straps_q <= st_s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_byte_valid <= 1'b0;
      cfg_byte <= 8'h00;
    end else begin
      cfg_byte_valid <= tg_ev[0];
      if (tg_ev[0]) cfg_byte <= cfg_hold;
    end
  end

  // serializer register file arbitration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_req <= 1'b0;
      fab_grant <= 1'b0;
      sd_jt <= 1'b0;
      sd_jt_d <= 1'b0;
      sd_we <= 1'b0;
      sd_addr <= 8'h00;
      sd_wdata <= 16'h0000;
      sd_mask <= 16'h0000;
      sd_read <= 16'h0000;
    end else begin
      sd_req <= tg_ev[2] | fab_req;
      fab_grant <= fab_req & ~tg_ev[2];
      sd_jt <= tg_ev[2];
      sd_jt_d <= sd_jt;
      if (tg_ev[2]) begin
        sd_we <= sd_word[`JCSB_SD_WE];
        sd_mask <= sd_word[`JCSB_SD_MASK];
        sd_wdata <= sd_word[`JCSB_SD_DATA];
        sd_addr <= sd_word[`JCSB_SD_ADDR];
      end else if (fab_req) begin
        sd_we <= fab_we;
        sd_mask <= fab_mask;
        sd_wdata <= fab_wdata;
        sd_addr <= fab_addr;
      end
      if (sd_jt_d) sd_read <= sd_rdata;
    end
  end

  jcsb_spi_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .start(tg_ev[1]),
    .word(fa_word),
    .cpol(straps_q[`JCSB_ST_CPOL]),
    .cpha(straps_q[`JCSB_ST_CPHA]),
    .page_idx(eng_idx),
    .page_word(page_mem[eng_idx]),
    .busy(eng_busy),
    .rx_data(eng_rx),
    .sclk(eng_sclk),
    .cs_n(eng_cs_n),
    .mosi(eng_mosi),
    .miso(spi_serial_in)
  );

  // spi pin selection
  assign spi_clk_o = is_byp ? tck : eng_sclk;
  assign spi_cs_n_o = is_byp ? ~shift_dr : eng_cs_n;
  assign spi_serial_out = is_byp ? tdi : eng_mosi;
  assign spi_clk_oe = is_byp | eng_busy;
  assign spi_cs_n_oe = is_byp | eng_busy;
  assign spi_serial_out_oe = is_byp | eng_busy;
  // boundary scan pins
  assign bs_extest = (ir == `JCSB_I_EXTEST) &&
                     (testmode == `JCSB_TM_BSCAN);
  assign bs_pin_drive = bs_upd;
  assign test_mode_select = testmode;

  sequence sd_grant_s;
    sd_req && !fab_grant ##2 (sd_read == $past(sd_rdata));
  endsequence

  AST_IR_LSB:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    (shift_ir && !capture_ir && !tap_reset) |=> ir_sh[5] == $past(tdi))
    else $error("instruction bit not entered at the top");
  AST_CFG_BYTE:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    (is_cfg && shift_dr && !capture_dr && cfg_cnt == 3'h7)
    |=> cfg_hold == $past({tdi, dr[7:1]}))
    else $error("configuration byte not packed");
  AST_BYP_WIRE:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    is_byp |-> (spi_serial_out == tdi && spi_clk_oe))
    else $error("spi bypass not connected");
  AST_BYP_TDO:
  assert property (@(negedge tck) disable iff (!rst_tck_n)
    (is_byp && shift_dr) |=> tdo == $past(byp_cap))
    else $error("bypass bit not on test output");
  AST_RX_FLAG:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    (is_rx && capture_dr && !tap_reset) |=> dr[0] == rx_valid)
    else $error("receive valid flag wrong");
  AST_TM_WRITE:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    (is_tm && update_dr && !tap_reset && !update_ir)
    |=> test_mode_select == $past(dr[1:0]))
    else $error("testmode not written");
  AST_PAGE_PTR:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    (update_ir && ir_sh == `JCSB_I_PAGE) |=> pg_ptr == 6'h00)
    else $error("page pointer not cleared");
  AST_EXTEST:
  assert property (@(posedge tck) disable iff (!rst_tck_n)
    bs_extest |-> (testmode == `JCSB_TM_BSCAN && !is_sample_only))
    else $error("pins driven outside external test");
  AST_SD_PRIO:
  assert property (@(posedge clk) disable iff (!rst_n)
    (tg_ev[2] && fab_req) |=> sd_grant_s)
    else $error("test port lost serializer arbitration");
endmodule

// ### rtl/jcsb_params.svh
// constants for the test port instruction block
`ifndef JCSB_PARAMS_SVH
`define JCSB_PARAMS_SVH
`define JCSB_IR_CAPT 6'h01
`define JCSB_I_FLASH 6'h01
`define JCSB_I_PAGE 6'h02
`define JCSB_I_RXDATA 6'h03
`define JCSB_I_BUSY 6'h04
`define JCSB_I_SPIBYP 6'h05
`define JCSB_I_CONFIG 6'h06
`define JCSB_I_TMODE 6'h20
`define JCSB_I_SDACC 6'h25
`define JCSB_I_SDRD 6'h26
`define JCSB_I_SAMPLE 6'h3D
`define JCSB_I_EXTEST 6'h3E
`define JCSB_I_BYPASS 6'h3F
`define JCSB_CFG_W 8
`define JCSB_PG_W 32
`define JCSB_FA_W 119
`define JCSB_RX_W 33
`define JCSB_SD_W 41
`define JCSB_SDR_W 16
`define JCSB_TM_W 2
`define JCSB_BS_W 317
`define JCSB_PAGE_WORDS 64
`define JCSB_F_CMDN 118:115
`define JCSB_F_ADRN 114:109
`define JCSB_F_MODN 108:105
`define JCSB_F_TXBN 104:99
`define JCSB_F_TXWN 98:92
`define JCSB_F_DMYN 91:86
`define JCSB_F_RXBN 85:80
`define JCSB_F_CMD 79:72
`define JCSB_F_MOD 71:64
`define JCSB_F_ADR 63:32
`define JCSB_F_TXD 31:0
`define JCSB_SD_WE 40
`define JCSB_SD_MASK 39:24
`define JCSB_SD_DATA 23:8
`define JCSB_SD_ADDR 7:0
`define JCSB_ST_CPOL 1
`define JCSB_ST_CPHA 0
`define JCSB_TM_OFF 2'h0
`define JCSB_TM_BSCAN 2'h3
`endif

// ### rtl/jcsb_pkg.sv
// types shared by the test port instruction block
package jcsb_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_ADDR = 3'b010,
    PH_MODE = 3'b011,
    PH_TX = 3'b100,
    PH_DUMMY = 3'b101,
    PH_RX = 3'b110,
    PH_DONE = 3'b111
  } jcsb_phase_type;
  typedef logic [5:0] jcsb_instr_type;
endpackage

// ### rtl/jcsb_spi_engine.sv
// spi flash access sequencer on the internal clock
`timescale 1ns/1ps
`include "jcsb_params.svh"
module jcsb_spi_engine import jcsb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [`JCSB_FA_W-1:0] word,
  input wire logic cpol,
  input wire logic cpha,
  // page buffer read
  output logic [5:0] page_idx,
  input wire logic [31:0] page_word,
  // status and result
  output logic busy,
  output logic [31:0] rx_data,
  // spi pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  jcsb_phase_type ph;
  logic [5:0] cnt;
  logic [6:0] wcnt;
  logic half;

  function automatic logic [6:0] plen(input jcsb_phase_type p,
                                      input logic [`JCSB_FA_W-1:0] w);
    case (p)
      PH_CMD: plen = {3'h0, w[`JCSB_F_CMDN]};
      PH_ADDR: plen = {1'b0, w[`JCSB_F_ADRN]};
      PH_MODE: plen = {3'h0, w[`JCSB_F_MODN]};
      PH_TX: plen = {1'b0, w[`JCSB_F_TXBN]};
      PH_DUMMY: plen = {1'b0, w[`JCSB_F_DMYN]};
      PH_RX: plen = {1'b0, w[`JCSB_F_RXBN]};
      default: plen = 7'h00;
    endcase
  endfunction

  function automatic jcsb_phase_type step(input jcsb_phase_type p);
    case (p)
      PH_CMD: step = PH_ADDR;
      PH_ADDR: step = PH_MODE;
      PH_MODE: step = PH_TX;
      PH_TX: step = PH_DUMMY;
      PH_DUMMY: step = PH_RX;
      PH_RX: step = PH_DONE;
      default: step = PH_IDLE;
    endcase
  endfunction

  function automatic logic pick(input logic [31:0] v, input logic [6:0] n,
                                input logic [5:0] c);
    logic [6:0] k;
    k = n - 7'h01 - {1'b0, c};
    pick = v[k[4:0]];
  endfunction

  wire [6:0] len = plen(ph, word);
  wire shifting = (len != 7'h00);
  wire last_bit = (({1'b0, cnt} + 7'h01) == len);
  wire more = (ph == PH_TX) && ((wcnt + 7'h01) < word[`JCSB_F_TXWN]);
  wire [31:0] tx_src = (wcnt == 7'h00) ? word[`JCSB_F_TXD] : page_word;
  wire [4:0] tx_pos = {~cnt[4:3], cnt[2:0]};
  wire [31:0] cmd_v = {24'h000000, word[`JCSB_F_CMD]};
  wire [31:0] mod_v = {24'h000000, word[`JCSB_F_MOD]};

  assign page_idx = wcnt[5:0];
  assign busy = (ph != PH_IDLE);
  assign cs_n = ~busy;
  assign sclk = shifting ? (cpol ^ half ^ cpha) : cpol;
  assign mosi = (ph == PH_CMD) ? pick(cmd_v, len, cnt) :
                (ph == PH_ADDR) ? pick(word[`JCSB_F_ADR], len, cnt) :
                (ph == PH_MODE) ? pick(mod_v, len, cnt) :
                (ph == PH_TX) ? tx_src[tx_pos] : 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= PH_IDLE;
      cnt <= 6'h00;
      wcnt <= 7'h00;
      half <= 1'b0;
    end else if (ph == PH_IDLE) begin
      if (start) begin
        ph <= PH_CMD;
        cnt <= 6'h00;
        wcnt <= 7'h00;
        half <= 1'b0;
      end
    end else if (ph == PH_DONE) begin
      ph <= PH_IDLE;
    end else if (!shifting) begin
      ph <= step(ph);
    end else begin
      half <= ~half;
      if (half) begin
        cnt <= last_bit ? 6'h00 : cnt + 6'h01;
        if (last_bit && more) wcnt <= wcnt + 7'h01;
        if (last_bit && !more) ph <= step(ph);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_data <= 32'h00000000;
    else if (ph == PH_IDLE && start) rx_data <= 32'h00000000;
    else if (ph == PH_RX && shifting && half) rx_data <= {rx_data[30:0], miso};
  end

  AST_ENG_START:
  assert property (@(posedge clk) disable iff (!rst_n)
    (ph == PH_IDLE && start) |=> (ph == PH_CMD && !cs_n))
    else $error("flash access did not start");
  AST_ENG_IDLE_CLK:
  assert property (@(posedge clk) disable iff (!rst_n)
    !busy |-> (sclk == cpol && cs_n))
    else $error("spi clock not at idle level");
endmodule

// ### testbench/jcsb_flash_model.sv
// spi flash stand-in on the far side of the spi pins
`timescale 1ns/1ps
module jcsb_flash_model (
  // spi pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // observed traffic
  output logic [63:0] got,
  output logic [31:0] sent
);
  logic [7:0] reply = 8'hA5;
  logic last = 1'b0;
  // deselected line shows the inverse of the last bit
  assign miso = cs_n ? ~last : reply[7];
  always @(posedge sclk) begin
    if (!cs_n) begin
      got <= {got[62:0], mosi};
      sent <= {sent[30:0], miso};
      last <= miso;
    end
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      reply <= {reply[6:0], ~reply[7]};
    end
  end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the test port instruction block
`timescale 1ns/1ps
`include "jcsb_params.svh"
module tb_top;
  logic clk = 1'b0, arst_n = 1'b0, tck = 1'b0, tdi = 1'b0, tap_reset = 1'b1;
  logic capture_ir = 1'b0, shift_ir = 1'b0, update_ir = 1'b0;
  logic capture_dr = 1'b0, shift_dr = 1'b0, update_dr = 1'b0;
  logic fab_req = 1'b0, fab_seen = 1'b0, path_ok, miso, tdo, spi_clk_o;
  logic spi_cs_n_o, spi_serial_out, sd_req, sd_we, fab_grant, bs_extest;
  logic cfg_byte_valid, tdo_oe, sout_oe, clk_oe, cs_oe;
  logic [3:0] straps = 4'hC;
  logic [7:0] cfg_byte, sd_addr;
  logic [15:0] sd_wdata, sd_mask, sd_rdata = 16'h0000;
  logic [316:0] bs_capture = '0, bs_pin_drive, dout, smp;
  logic [1:0] test_mode_select;
  logic [63:0] got;
  logic [31:0] sent;
  logic [41:0] sd_seen;
  logic [7:0] cfg_q[$];
  int miscompares = 0, total_checks = 0, cyc = 0;

  jcsb_port dut (.clk(clk), .arst_n(arst_n), .tck(tck), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .tap_reset(tap_reset), .capture_ir(capture_ir),
    .shift_ir(shift_ir), .update_ir(update_ir), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr),
    .config_mode_straps(straps),
    .spi_clk_o(spi_clk_o), .spi_clk_oe(clk_oe), .spi_cs_n_o(spi_cs_n_o),
    .spi_cs_n_oe(cs_oe), .spi_serial_out(spi_serial_out),
    .spi_serial_out_oe(sout_oe), .spi_serial_in(miso), .cfg_byte(cfg_byte),
    .cfg_byte_valid(cfg_byte_valid), .sd_req(sd_req), .sd_we(sd_we),
    .sd_addr(sd_addr), .sd_wdata(sd_wdata), .sd_mask(sd_mask),
    .sd_rdata(sd_rdata), .fab_req(fab_req), .fab_we(1'b1),
    .fab_addr(8'h11), .fab_wdata(16'h0000), .fab_mask(16'h0000),
    .fab_grant(fab_grant), .bs_capture(bs_capture),
    .bs_pin_drive(bs_pin_drive), .bs_extest(bs_extest),
    .test_mode_select(test_mode_select));
  jcsb_flash_model flash (.sclk(spi_clk_o), .cs_n(spi_cs_n_o),
    .mosi(spi_serial_out), .miso(miso), .got(got), .sent(sent));

  always #20 clk = ~clk;
  // serializer file answer, byte queue, watchdog
  always @(posedge clk) begin
    if (sd_req) begin
      sd_rdata <= #1 {sd_addr, 8'hC3};
    end
    if (sd_req && sd_addr !== 8'h11) begin
      sd_seen <= {fab_grant, sd_we, sd_mask, sd_wdata, sd_addr};
    end
    if (fab_grant) begin
      fab_seen <= 1'b1;
    end
    if (cfg_byte_valid) begin
      cfg_q.push_back(cfg_byte);
    end
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results;
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic [316:0] g, input logic [316:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rise;
    #61.5 tck = 1'b1;
    #1;
  endtask
  task automatic fall;
    #61.5 tck = 1'b0;
    #1;
  endtask
  task automatic tk;
    fall;
    rise;
  endtask
  task automatic ir(input logic [5:0] c);
    logic [5:0] o;
    capture_ir = 1'b1;
    tk;
    capture_ir = 1'b0;
    shift_ir = 1'b1;
    for (int i = 0; i < 6; i++) begin
      tdi = c[i];
      tk;
      o[i] = tdo;
    end
    shift_ir = 1'b0;
    update_ir = 1'b1;
    tk;
    update_ir = 1'b0;
    chk(64'(o), 64'h01);
  endtask
  task automatic dr(input int n, input logic [316:0] d);
    dout = '0;
    capture_dr = 1'b1;
    tk;
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    path_ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi = d[i];
      fall;
      rise;
      smp[i] = miso;
      dout[i] = tdo;
      path_ok &= spi_serial_out === tdi && spi_clk_o === 1'b1;
      path_ok &= spi_cs_n_o === 1'b0 && tdo_oe === 1'b1;
      path_ok &= clk_oe === 1'b1 && cs_oe === 1'b1 && sout_oe === 1'b1;
    end
    shift_dr = 1'b0;
    update_dr = 1'b1;
    tk;
    update_dr = 1'b0;
  endtask
  task automatic wait_idle;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 400 && spi_cs_n_o !== 1'b1; k++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_bypass;
    ir(6'h15);
    dr(4, 317'hB);
    chk(64'(dout[3:0]), 64'h6);
    $display("one-bit bypass test done");
  endtask
  task automatic t_spi_bypass;
    ir(`JCSB_I_BUSY);
    dr(1, '0);
    chk(64'(dout[0]), 64'h0);
    ir(`JCSB_I_SPIBYP);
    dr(9, 317'h1A5);
    chk(64'(path_ok), 64'h1);
    chk(64'(dout[8:1]), 64'(smp[7:0]));
    chk(64'(spi_cs_n_o), 64'h1);
    $display("spi bypass test done");
  endtask
  task automatic t_flash;
    logic [316:0] w;
    w = '0;
    w[`JCSB_F_CMDN] = 4'h8;
    w[`JCSB_F_RXBN] = 6'h20;
    w[`JCSB_F_CMD] = 8'h9F;
    ir(`JCSB_I_FLASH);
    dr(`JCSB_FA_W, w);
    ir(`JCSB_I_BUSY);
    dr(1, '0);
    chk(64'(dout[0]), 64'h1);
    wait_idle;
    chk(64'(got[39:32]), 64'h9F);
    chk(64'({clk_oe, cs_oe, sout_oe}), 64'h0);
    ir(`JCSB_I_FLASH);
    ir(`JCSB_I_RXDATA);
    dr(`JCSB_RX_W, '0);
    chk(64'(dout[32:0]), {31'h0, sent, 1'b1});
    ir(`JCSB_I_RXDATA);
    dr(`JCSB_RX_W, '0);
    chk(64'(dout[0]), 64'h0);
    $display("flash access test done");
  endtask
  task automatic t_page;
    logic [316:0] w;
    w = '0;
    w[`JCSB_F_TXBN] = 6'h20;
    w[`JCSB_F_TXWN] = 7'h02;
    w[`JCSB_F_TXD] = 32'h00000001;
    straps = 4'hF;
    ir(`JCSB_I_PAGE);
    dr(`JCSB_PG_W, 317'h00000001);
    dr(`JCSB_PG_W, 317'h00000102);
    ir(`JCSB_I_FLASH);
    dr(`JCSB_FA_W, w);
    wait_idle;
    chk(got, 64'h8000000040800000);
    chk(64'(spi_clk_o), 64'h1);
    straps = 4'hC;
    $display("page buffer test done");
  endtask
  task automatic t_serdes;
    @(posedge clk);
    #1 fab_req = 1'b1;
    ir(`JCSB_I_SDACC);
    dr(`JCSB_SD_W, 317'h1F0F012345A);
    repeat (10) @(posedge clk);
    #1 fab_req = 1'b0;
    chk(64'(sd_seen), 64'h1F0F012345A);
    chk(64'(fab_seen), 64'h1);
    ir(`JCSB_I_SDRD);
    dr(`JCSB_SDR_W, '0);
    chk(64'(dout[15:0]), 64'h5AC3);
    $display("serializer test done");
  endtask
  task automatic t_config;
    ir(`JCSB_I_CONFIG);
    dr(16, 317'h3CA5);
    repeat (10) @(posedge clk);
    chk(64'(cfg_q.size()), 64'h2);
    chk(64'({cfg_q[0], cfg_q[1]}), 64'hA53C);
    $display("configuration test done");
  endtask
  task automatic t_bscan;
    logic [316:0] p;
    p = 317'({10{32'h96C35A0F}});
    bs_capture = p;
    ir(`JCSB_I_TMODE);
    dr(`JCSB_TM_W, 317'h3);
    chk(64'(test_mode_select), 64'h3);
    ir(`JCSB_I_SAMPLE);
    dr(`JCSB_BS_W, ~p);
    chkb(dout, p);
    chkb(bs_pin_drive, ~p);
    chk(64'(bs_extest), 64'h0);
    ir(`JCSB_I_EXTEST);
    chk(64'(bs_extest), 64'h1);
    tap_reset = 1'b1;
    tk;
    tap_reset = 1'b0;
    chk(64'(test_mode_select), 64'h0);
    $display("boundary scan test done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) tk;
    tap_reset = 1'b0;
    t_bypass;
    t_spi_bypass;
    t_flash;
    t_page;
    t_serdes;
    t_config;
    t_bscan;
    results;
  end
endmodule
